//--- dv/host_model.sv
// Host serial master that frames conversions and shifts commands.
// Assumes the block drives the result on falls and we sample on rises.
`timescale 1ns/100ps
`default_nettype none
module host_model
    import adc_sel_pkg::*;
(
    // Link pins
    output logic            serial_clk,
    output var link_in_t    link_in,
    input  wire link_out_t  link_out
);
    logic [15:0] shift_reg;
    int          oe_bad;
    // Clock idles high between frames, so the first fall counts as fall 1
    initial begin
        serial_clk = 1'b1;
        link_in    = '{1'b1, 1'b0};
        shift_reg  = 16'h0000;
        oe_bad     = 0;
    end
    // One frame of n conversions with the same command
    task automatic frame(input logic [7:0] cmd, input int n,
                         output logic [15:0] res);
        int i;
        link_in.frame_select_n = 1'b0;
        for (i = 0; i < 16 * n; i++) begin
            #24 serial_clk = 1'b0;
            // Past the command, keep the data line toggling
            if (i % 16 < 8)
                link_in.serial_cmd_in = cmd[7 - i % 16];
            else
                link_in.serial_cmd_in = ~link_in.serial_cmd_in;
            #24 serial_clk = 1'b1;
            shift_reg = {shift_reg[14:0], link_out.serial_result_out};
            if (link_out.serial_result_oe !== 1'b1)
                oe_bad++;
        end
        #24 link_in.frame_select_n = 1'b1;
        link_in.serial_cmd_in = ~link_in.serial_cmd_in;
        res = shift_reg;
    endtask
endmodule // host_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench: frames commands, compares results and channel.
// Assumes host_model drives the link and the bench drives the core side.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import adc_sel_pkg::*;
    logic          core_clk;
    logic          resetn;
    logic [7:0]    sample_code;
    logic [2:0]    active_channel;
    logic          hold_mode;
    logic          serial_clk;
    link_in_t      link_in;
    link_out_t     link_out;
    logic [15:0]   res;
    int            mismatches;
    int            total_checks;
    int            k;
    adc_serial_channel_select i_adc_serial_channel_select (
        .core_clk(core_clk), .resetn(resetn), .sample_code(sample_code),
        .active_channel(active_channel), .hold_mode(hold_mode),
        .serial_clk(serial_clk), .link_in(link_in), .link_out(link_out));
    host_model i_host_model (
        .serial_clk(serial_clk), .link_in(link_in), .link_out(link_out));
    // Core clock at 20 MHz
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Inputs move a fixed 5 ns after the core edge
    task automatic wait_core(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask
    // Guard against a hung sequence
    initial begin
        #200us;
        mismatches++;
        conclude();
    end
    initial begin
        mismatches = 0;
        total_checks = 0;
        resetn = 1'b0;
        sample_code = 8'h00;
        wait_core(10);
        resetn = 1'b1;
        wait_core(4);
        check("chan_reset", 16'(active_channel), 16'h0000);
        check("oe_idle", 16'(link_out.serial_result_oe), 16'h0000);
        // Walk every channel code with the ignored bits disturbed
        for (k = 0; k < 9; k++) begin
            sample_code = (k == 8) ? 8'hff : 8'(8'h5a ^ (k * 8'h13));
            wait_core(4);
            check("chan_prev", 16'(active_channel),
                  16'(k == 0 ? 0 : (k - 1) % 8));
            i_host_model.frame({2'(~k), 3'(k), 3'(5 ^ k)}, 1, res);
            check("result", res, {4'h0, sample_code, 4'h0});
            wait_core(6);
            check("chan_load", 16'(active_channel), 16'(k % 8));
        end
        // Two conversions in one frame, second one shows the new channel
        sample_code = 8'h3c;
        wait_core(4);
        fork
            i_host_model.frame(8'h10, 2, res);
            begin
                wait_core(10);
                check("hold_conv", 16'(hold_mode), 16'h0001);
            end
        join
        check("result_cont", res, {4'h0, 8'h3c, 4'h0});
        check("oe_frame", 16'(i_host_model.oe_bad), 16'h0000);
        wait_core(6);
        check("hold_idle", 16'(hold_mode), 16'h0000);
        check("chan_cont", 16'(active_channel), 16'h0002);
        // Second reset brings the channel back to input 0
        resetn = 1'b0;
        wait_core(2);
        resetn = 1'b1;
        wait_core(4);
        check("chan_rereset", 16'(active_channel), 16'h0000);
        conclude();
    end
endmodule // tb
`default_nettype wire

//--- hdl/adc_serial_channel_select.sv
// Serial command capture, channel select and result shifter.
// Assumes the host frames with frame_select_n and clocks with serial_clk;
// the core side delivers a conversion sample in core_clk.
// How it works
// - Frame select falling with clock low starts track mode at once.
// - Command captured MSB first on first 8 rising edges of each conversion.
// - Captured channel code applies to the next conversion only.
// - Channel selection is input 0 after power-up.
// - First conversion after power-up is already a valid result.
// - Command bits 7, 6, 2, 1, 0 are ignored.
// - Bits 5..3 are an unsigned channel code, bit 5 most significant.
// - Result is straight binary, zeros low, ones full scale.
// - Falls 1-4 zeros, 5-12 result MSB first, 13-16 zeros.
// - Output released while frame select high; clock then ignored.
// - Track again after each 16th rise; convert from fourth fall.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_channel_select
    import adc_sel_pkg::*;
(
    // Core side
    input  wire logic                core_clk,
    input  wire logic                resetn,
    input  wire logic [RES_BITS-1:0] sample_code,
    output logic      [2:0]          active_channel,
    output logic                     hold_mode,
    // Link side
    input  wire logic                serial_clk,
    input  wire link_in_t            link_in,
    output var link_out_t            link_out
);
    // Link domain: sclk gated by frame select via async clear of counter
    logic [3:0]          rise_cnt_reg, rise_cnt_next;
    logic [3:0]          fall_cnt_reg, fall_cnt_next;
    logic [CMD_BITS-1:0] cmd_reg, cmd_next;
    logic [2:0]          chan_reg, chan_next;   // channel for current conv
    logic [2:0]          pend_reg, pend_next;   // code for next conversion
    logic [RES_BITS-1:0] res_reg, res_next;
    logic                dout_reg, dout_next;
    conv_state_t         st_reg, st_next;
    logic                frame_rst_n;

    // Frame select high holds the link logic idle; clock ignored then
    assign frame_rst_n = ~link_in.frame_select_n;

    // Rising-edge logic: command capture and conversion count
    always_comb begin
        rise_cnt_next = rise_cnt_reg + 4'h1; // wraps every 16 edges
        cmd_next      = cmd_reg;
        pend_next     = pend_reg;
        chan_next     = chan_reg;
        if (rise_cnt_reg <= CMD_LAST_EDGE) begin
            cmd_next = {cmd_reg[CMD_BITS-2:0], link_in.serial_cmd_in};
        end
        if (rise_cnt_reg == CMD_LAST_EDGE) begin
            // Only the address field is kept; others dropped
            pend_next = {cmd_reg[CODE_MSB_POS-1:CODE_LSB_POS-1]};
        end
        if (rise_cnt_reg == 4'hf) begin
            chan_next = pend_reg;
        end
    end

    // Channel and pending code survive frames; cleared only by resetn
    always_ff @(posedge serial_clk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= CHAN_RESET;
            chan_reg <= CHAN_RESET;
        end else if (frame_rst_n) begin
            pend_reg <= pend_next;
            chan_reg <= chan_next;
        end
    end

    always_ff @(posedge serial_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rise_cnt_reg <= CNT_RESET;
            cmd_reg      <= CMD_RESET;
        end else begin
            rise_cnt_reg <= rise_cnt_next;
            cmd_reg      <= cmd_next;
        end
    end

    // Crossing of the sample word: core holds it stable per conversion.
    // Both flops run on the falling edge, so by fall 4 the word has been
    // through two stages; a word that moves mid-frame may tear, which is
    // why the core must hold it for the whole conversion.
    logic [RES_BITS-1:0] samp_meta_reg, samp_sync_reg;
    always_ff @(negedge serial_clk or negedge resetn) begin
        if (!resetn) begin
            samp_meta_reg <= '0;
            samp_sync_reg <= '0;
        end else begin
            samp_meta_reg <= sample_code;
            samp_sync_reg <= samp_meta_reg;
        end
    end

    // Falling-edge logic: track/convert state and result shifting.
    // The fall number comes from the rises seen so far: fall k always
    // lies between rise k-1 and rise k, whether frame select dropped with
    // the clock high, low or together with it. No clock level has to be
    // sampled at the frame edge, and a fall that races the frame edge is
    // fall 1 either way, which only pads a zero.
    always_comb begin
        fall_cnt_next = rise_cnt_reg + 4'h1;
        st_next       = st_reg;
        res_next      = res_reg;
        dout_next     = 1'b0;                   // pad zeros
        // Fourth fall: sample frozen, conversion starts
        if (fall_cnt_next == TRACK_FALLS) begin
            st_next  = ST_CONVERT;
            res_next = samp_sync_reg;
        end
        // Fall after each 16th rise wraps to 1: back to tracking
        if (fall_cnt_next == 4'h1) begin
            st_next = ST_TRACK;
        end
        // Result window, most significant bit first
        if ((fall_cnt_next >= RES_FIRST_FALL) &&
            (fall_cnt_next <= RES_LAST_FALL)) begin
            dout_next = res_reg[RES_BITS-1];
            res_next  = {res_reg[RES_BITS-2:0], 1'b0};
        end
    end

    // Falling-edge registers; frame select high clears them at once
    always_ff @(negedge serial_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fall_cnt_reg <= CNT_RESET;
            st_reg       <= ST_TRACK;
            res_reg      <= '0;
            dout_reg     <= 1'b0;
        end else begin
            fall_cnt_reg <= fall_cnt_next;
            st_reg       <= st_next;
            res_reg      <= res_next;
            dout_reg     <= dout_next;
        end
    end

    // Enable follows frame select with no clock, so the pin is released
    // even if the host stops the clock mid-frame
    assign link_out = {dout_reg, frame_rst_n};

    // Core-domain status: two-flop sync of link state.
    // The channel moves only at the 16th rise and then stands for a whole
    // conversion, so a torn multi-bit read lasts one core cycle at most.
    logic [2:0] ch_m_reg, ch_s_reg;
    logic       hd_m_reg, hd_s_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ch_m_reg <= CHAN_RESET;
            ch_s_reg <= CHAN_RESET;
            hd_m_reg <= 1'b0;
            hd_s_reg <= 1'b0;
        end else begin
            ch_m_reg <= chan_reg;
            ch_s_reg <= ch_m_reg;
            hd_m_reg <= (st_reg == ST_CONVERT);
            hd_s_reg <= hd_m_reg;
        end
    end
    assign active_channel = ch_s_reg;
    assign hold_mode      = hd_s_reg;

    // Checks on the core-side reset value and the link domain
    a_chan_reset: assert property (@(posedge core_clk)
        $rose(resetn) |-> active_channel == CHAN_RESET)
        else $error("channel not zero after reset");
    a_oe_frame: assert property (@(posedge serial_clk)
        link_out.serial_result_oe == ~link_in.frame_select_n)
        else $error("output enable wrong");
    a_pad_zero: assert property (@(negedge serial_clk)
        disable iff (!frame_rst_n)
        (fall_cnt_reg < RES_FIRST_FALL || fall_cnt_reg > RES_LAST_FALL)
        |-> link_out.serial_result_out == 1'b0)
        else $error("pad bit not zero");

    // State against the fall number of the last falling edge
    a_load_conv: assert property (@(negedge serial_clk)
        disable iff (!frame_rst_n)
        fall_cnt_reg == TRACK_FALLS |-> st_reg == ST_CONVERT)
        else $error("not converting after fourth fall");
    a_track_wrap: assert property (@(negedge serial_clk)
        disable iff (!frame_rst_n)
        fall_cnt_reg == 4'h1 |-> st_reg == ST_TRACK)
        else $error("not tracking at first fall");

    // Command path checks
    a_code_next: assert property (@(posedge serial_clk) disable iff (!frame_rst_n)
        rise_cnt_reg == 4'hf |=> chan_reg == $past(pend_reg))
        else $error("channel not updated at conversion end");
    a_cmd_field: assert property (@(posedge serial_clk) disable iff (!frame_rst_n)
        rise_cnt_reg == 4'h8 |-> pend_reg == cmd_reg[5:3])
        else $error("channel code field wrong");
    c_convert: cover property (@(negedge serial_clk) st_reg == ST_CONVERT);
    c_wrap: cover property (@(posedge serial_clk) rise_cnt_reg == 4'hf);
    c_newchan: cover property (@(posedge serial_clk) $changed(chan_reg));
    c_result: cover property (@(negedge serial_clk)
        fall_cnt_reg == RES_LAST_FALL);
    c_hold_core: cover property (@(posedge core_clk) $rose(hold_mode));
endmodule // adc_serial_channel_select
`default_nettype wire

//--- pkg/adc_sel_pkg.sv
// Constants and carrier types for the serial channel-select converter.
// Assumes one serial-clock link domain and one core_clk domain.
package adc_sel_pkg;
    localparam int          CMD_BITS      = 8;
    localparam int          RES_BITS      = 8;
    localparam int          CONV_EDGES    = 16;
    localparam logic [3:0]  CMD_LAST_EDGE = 4'h7;  // rising edges 0..7
    localparam logic [3:0]  RES_FIRST_FALL = 4'h5;
    localparam logic [3:0]  RES_LAST_FALL  = 4'hc;
    localparam logic [3:0]  TRACK_FALLS    = 4'h4;
    localparam int          CODE_MSB_POS  = 5;
    localparam int          CODE_LSB_POS  = 3;
    localparam logic [2:0]  CHAN_RESET    = 3'h0;
    localparam logic [3:0]  CNT_RESET     = 4'h0;
    localparam logic [7:0]  CMD_RESET     = 8'h00;

    typedef enum logic [1:0] {
        ST_TRACK   = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    // Pin group facing the host
    typedef struct packed {
        logic frame_select_n;
        logic serial_cmd_in;
    } link_in_t;

    typedef struct packed {
        logic serial_result_out;
        logic serial_result_oe;
    } link_out_t;
endpackage
